// *** include/fifo_rsel_pkg.sv ***
package fifo_rsel_pkg;

  localparam int DATA_W = 36;
  localparam int DEPTH  = 16;
  localparam int AW     = 4;
  localparam int PW     = 5;
  localparam int OFF_W  = 4;

  localparam logic [PW-1:0] FULL_COUNT = 5'h10;
  localparam logic [1:0]    FALL_LAST  = 2'h2;

  localparam logic [11:0] ADDR_STATUS  = 12'h000;
  localparam logic [11:0] ADDR_OFFSETS = 12'h004;

  localparam int ST_EMPTY_BIT  = 0;
  localparam int ST_AE_BIT     = 1;
  localparam int ST_AF_BIT     = 2;
  localparam int ST_FULL_BIT   = 3;
  localparam int ST_CFG_LSB    = 4;
  localparam int ST_COUNT_LSB  = 16;
  localparam int OFF_EMPTY_LSB = 0;
  localparam int OFF_FULL_LSB  = 8;

  localparam logic [DATA_W-1:0] OUT_RESET = 36'h0;

  // Default offsets picked by {load, pick1, pick0} at master reset
  localparam logic [OFF_W-1:0] DEFAULT_OFF [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};

  typedef struct packed {
    logic [DATA_W-1:0] data_in;
    logic              write_en_n;
    logic              read_select_n;
    logic              read_en_n;
    logic              output_en_n;
    logic              master_reset_n;
    logic              partial_reset_n;
    logic              offset_access_n;
    logic              serial_load_en_n;
    logic              serial_clk;
    logic              fall_through_si;
    logic              retransmit_n;
    logic              mark_n;
    logic              default_pick_0;
    logic              default_pick_1;
    logic              flag_timing_sel;
    logic              write_port_io_std_sel;
    logic              read_port_io_std_sel;
    logic              system_io_std_sel;
  } pins_s;

  localparam pins_s PINS_RESET = '{data_in: 36'h0, write_en_n: 1'b1, read_select_n: 1'b1, read_en_n: 1'b1,
                                   output_en_n: 1'b1, master_reset_n: 1'b0, partial_reset_n: 1'b1,
                                   offset_access_n: 1'b1, serial_load_en_n: 1'b1, serial_clk: 1'b0,
                                   fall_through_si: 1'b0, retransmit_n: 1'b1, mark_n: 1'b1,
                                   default_pick_0: 1'b0, default_pick_1: 1'b0, flag_timing_sel: 1'b0,
                                   write_port_io_std_sel: 1'b0, read_port_io_std_sel: 1'b0,
                                   system_io_std_sel: 1'b0};

  typedef struct packed {
    logic write_port_hstl;
    logic read_port_hstl;
    logic system_hstl;
    logic fall_through_mode;
    logic parallel_prog;
    logic sync_flags;
  } cfg_s;

  localparam cfg_s CFG_RESET = 6'h0;

  typedef struct packed {
    logic [11:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        psel;
    logic        penable;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

endpackage : fifo_rsel_pkg

// *** logic/fifo_read_select.sv ***
`timescale 1ns/1ps

// Summary of operation
// - Select low drives data bus next edge
// - Select high floats data bus next edge
// - Select ignored during master or partial reset
// - Output enable drives bus through first post-reset edge
// - Flags update regardless of read select
// - Fall-through first word loads without select
// - Select and read enable low advance word
// - Retransmit only while select held low
// - I/O standard selects latched at master reset
// - Load and picks latch default offsets, method
// - Offset writes only by latched method
// - Offset readback only over parallel path
// - Load low starts offset load; readback needs no load
// - Flag timing select latched at master reset
// - Async almost-empty: read asserts, write releases
// - Async almost-full: write asserts, read releases
// - Fall-through word appears after three edges
// - Serial shift per rising serial clock edge
module fifo_read_select
  import fifo_rsel_pkg::*;
(
  input  wire logic              clk,            // 100 MHz clock
  input  wire logic              rstn,           // Async reset, active low
  input  wire logic              ce,             // Clock enable
  input  wire pins_s             pins,           // Device pins, asynchronous
  input  wire apb_req_s          apb_req,        // APB request
  output apb_rsp_s               apb_rsp,        // APB response
  output logic     [DATA_W-1:0]  data_out_bus,   // Output register
  output logic                   data_out_oe,    // Data bus drive enable
  output logic                   empty_flag_n,   // Empty or output-ready, low active
  output logic                   almost_empty_n, // Almost empty, low active
  output logic                   almost_full_n,  // Almost full, low active
  output logic                   full_flag_n,    // Full, low active
  output cfg_s                   cfg             // Configuration latched at master reset
);

  localparam int PIN_W = $bits(pins_s);

  logic [PIN_W-1:0]  sync1;
  logic [PIN_W-1:0]  sync2;
  logic [PIN_W-1:0]  sync3;
  logic [PIN_W-1:0]  pin_bits;
  pins_s             pin;
  logic              rst_active;
  logic              master_active;
  logic              rst_window;
  logic              sclk_prev;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [PW-1:0]     wptr;
  logic [PW-1:0]     rptr;
  logic [PW-1:0]     mark_ptr;
  logic [PW-1:0]     count;
  logic              out_valid;
  logic [1:0]        fall_cnt;
  logic [OFF_W-1:0]  empty_off;
  logic [OFF_W-1:0]  full_off;
  logic              wr_evt;
  logic              rd_std;
  logic              rd_fall_through_mode;
  logic              fall_load;
  logic              pop;
  logic              retx;
  logic              ae;
  logic              af;
  logic              shift;
  logic              acc;
  logic              setup;
  logic              off_write;
  logic              refuse;
  logic              addr_ok;
  logic [31:0]       status_word;
  logic [31:0]       offsets_word;
  logic [DATA_W-1:0] head;

  // Three-stage pin synchroniser, a bit changes once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1    <= PINS_RESET;
      sync2    <= PINS_RESET;
      sync3    <= PINS_RESET;
      pin_bits <= PINS_RESET;
    end else if (ce) begin
      sync1    <= pins;
      sync2    <= sync1;
      sync3    <= sync2;
      pin_bits <= (sync2 & ~(sync2 ^ sync3)) | (pin_bits & (sync2 ^ sync3));
    end
  end

  assign pin           = pins_s'(pin_bits);
  assign master_active = ~pin.master_reset_n;
  assign rst_active    = master_active | ~pin.partial_reset_n;
  assign count         = wptr - rptr;
  assign head          = mem[rptr[AW-1:0]];

  // Memory accesses need no reset, and load high except the fall-through first-word load
  assign wr_evt    = ~pin.write_en_n & (count != FULL_COUNT) & ~rst_active & pin.offset_access_n;
  assign rd_std    = ~cfg.fall_through_mode & ~pin.read_select_n & ~pin.read_en_n
                     & (count != '0) & ~rst_active & pin.offset_access_n;
  assign rd_fall_through_mode   = cfg.fall_through_mode & out_valid & ~pin.read_select_n & ~pin.read_en_n
                     & ~rst_active & pin.offset_access_n;
  assign fall_load = cfg.fall_through_mode & ~out_valid & (count != '0)
                     & (fall_cnt == FALL_LAST) & ~rst_active;
  assign retx      = ~pin.retransmit_n & ~pin.read_select_n & ~rst_active;
  assign pop       = ~retx & (rd_std | fall_load | (rd_fall_through_mode & (count != '0)));

  // Configuration and default offsets are captured while master reset is held
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= CFG_RESET;
    end else if (ce && master_active) begin
      cfg.write_port_hstl   <= pin.write_port_io_std_sel;
      cfg.read_port_hstl    <= pin.read_port_io_std_sel;
      cfg.system_hstl       <= pin.system_io_std_sel;
      cfg.fall_through_mode <= pin.fall_through_si;
      cfg.parallel_prog     <= pin.offset_access_n;
      cfg.sync_flags        <= pin.flag_timing_sel;
    end
  end

  // Reset window covers reset and the first edge after its release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_window <= 1'b1;
    end else if (ce) begin
      rst_window <= rst_active;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_out_oe <= 1'b0;
    end else if (ce) begin
      data_out_oe <= ~pin.output_en_n & (rst_active | rst_window | ~pin.read_select_n);
    end
  end

  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_mem
      always_ff @(posedge clk) begin
        if (ce && wr_evt && (wptr[AW-1:0] == AW'(i))) begin
          mem[i] <= pin.data_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr     <= '0;
      mark_ptr <= '0;
    end else if (ce) begin
      if (rst_active) begin
        wptr     <= '0;
        mark_ptr <= '0;
      end else begin
        if (wr_evt) begin
          wptr <= wptr + PW'(1);
        end
        if (~pin.mark_n) begin
          mark_ptr <= rptr;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rptr <= '0;
    end else if (ce) begin
      if (rst_active) begin
        rptr <= '0;
      end else if (retx) begin
        rptr <= mark_ptr;
      end else if (pop) begin
        rptr <= rptr + PW'(1);
      end
    end
  end

  // Fall-through counter runs whether or not the select is active
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fall_cnt <= '0;
    end else if (ce) begin
      if (cfg.fall_through_mode && !out_valid && count != '0 && !rst_active && fall_cnt != FALL_LAST) begin
        fall_cnt <= fall_cnt + 2'h1;
      end else begin
        fall_cnt <= '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_out_bus <= OUT_RESET;
      out_valid    <= 1'b0;
    end else if (ce) begin
      if (rst_active) begin
        data_out_bus <= OUT_RESET;
        out_valid    <= 1'b0;
      end else if (retx) begin
        out_valid <= 1'b0;
      end else if (pop) begin
        data_out_bus <= head;
        out_valid    <= 1'b1;
      end else if (rd_fall_through_mode) begin
        out_valid <= 1'b0;
      end
    end
  end

  // Status flags, independent of the read select
  assign ae = count <= PW'(empty_off);
  assign af = count >= (FULL_COUNT - PW'(full_off));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      empty_flag_n <= 1'b0;
      full_flag_n  <= 1'b1;
    end else if (ce) begin
      empty_flag_n <= cfg.fall_through_mode ? ~out_valid : (count != '0);
      full_flag_n  <= count != FULL_COUNT;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      almost_empty_n <= 1'b0;
    end else if (ce) begin
      if (rst_active) begin
        almost_empty_n <= 1'b0;
      end else if (cfg.sync_flags) begin
        almost_empty_n <= ~ae;
      end else if (ae && !wr_evt) begin
        almost_empty_n <= 1'b0;
      end else if (!ae && wr_evt) begin
        almost_empty_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      almost_full_n <= 1'b1;
    end else if (ce) begin
      if (rst_active) begin
        almost_full_n <= 1'b1;
      end else if (cfg.sync_flags) begin
        almost_full_n <= ~af;
      end else if (af && wr_evt) begin
        almost_full_n <= 1'b0;
      end else if (!af && !wr_evt) begin
        almost_full_n <= 1'b1;
      end
    end
  end

  // Offset programming, serial through pins or parallel through the bus
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_prev <= 1'b0;
    end else if (ce) begin
      sclk_prev <= pin.serial_clk;
    end
  end

  assign shift = ~cfg.parallel_prog & ~pin.offset_access_n & ~pin.serial_load_en_n
                 & pin.serial_clk & ~sclk_prev & ~master_active;
  assign setup     = apb_req.psel & ~apb_req.penable;
  assign acc       = apb_req.psel & apb_req.penable & apb_rsp.pready;
  assign addr_ok   = (apb_req.paddr == ADDR_STATUS) | (apb_req.paddr == ADDR_OFFSETS);
  assign refuse    = apb_req.pwrite & ((apb_req.paddr == ADDR_STATUS)
                     | ~cfg.parallel_prog | pin.offset_access_n);
  assign off_write = acc & apb_req.pwrite & (apb_req.paddr == ADDR_OFFSETS) & ~apb_rsp.pslverr;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      empty_off <= DEFAULT_OFF[0];
      full_off  <= DEFAULT_OFF[0];
    end else if (ce) begin
      if (master_active) begin
        empty_off <= DEFAULT_OFF[{pin.offset_access_n, pin.default_pick_1, pin.default_pick_0}];
        full_off  <= DEFAULT_OFF[{pin.offset_access_n, pin.default_pick_1, pin.default_pick_0}];
      end else if (shift) begin
        {full_off, empty_off} <= {full_off[OFF_W-2:0], empty_off, pin.fall_through_si};
      end else if (off_write) begin
        empty_off <= apb_req.pwdata[OFF_EMPTY_LSB +: OFF_W];
        full_off  <= apb_req.pwdata[OFF_FULL_LSB +: OFF_W];
      end
    end
  end

  assign status_word  = {11'h0, count, 6'h0, cfg, full_flag_n, almost_full_n, almost_empty_n, empty_flag_n};
  assign offsets_word = {20'h0, full_off, 4'h0, empty_off};

  // Answer is decided in the setup cycle and presented in the access cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      apb_rsp <= '0;
    end else if (ce) begin
      apb_rsp.pready  <= setup;
      apb_rsp.pslverr <= setup & (~addr_ok | refuse);
      if (setup && !apb_req.pwrite && apb_req.paddr == ADDR_OFFSETS) begin
        apb_rsp.prdata <= offsets_word;
      end else if (setup && !apb_req.pwrite && apb_req.paddr == ADDR_STATUS) begin
        apb_rsp.prdata <= status_word;
      end else begin
        apb_rsp.prdata <= '0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_run;
    ce && !rst_active && !rst_window;
  endsequence

  sequence s_fall_edge;
    ce && cfg.fall_through_mode && !out_valid && count != '0 && !rst_active && !retx;
  endsequence

  a_select_drive: assert property (s_run and (!pin.output_en_n && !pin.read_select_n) |=> data_out_oe)
    else $error("bus not driven after select low");
  a_select_float: assert property (s_run and pin.read_select_n |=> !data_out_oe)
    else $error("bus not floated after select high");
  a_reset_ignore: assert property (ce && rst_active && !pin.output_en_n |=> data_out_oe)
    else $error("select acted during reset");
  a_window_hold: assert property (ce && $fell(rst_active) ##0 !pin.output_en_n |=> data_out_oe)
    else $error("bus floated in reset window");
  a_empty_flag: assert property (ce && !cfg.fall_through_mode && count != '0 |=> empty_flag_n)
    else $error("empty flag stuck low");
  a_fall_three: assert property (s_fall_edge ##1 s_fall_edge ##1 s_fall_edge |=> out_valid)
    else $error("first word did not fall through");
  a_read_advance: assert property (ce && rd_std && !retx |=> data_out_bus == $past(head) && rptr == $past(rptr) + 5'h1)
    else $error("read did not advance");
  a_retx_select: assert property (ce && retx |=> rptr == $past(mark_ptr))
    else $error("retransmit not taken");
  a_no_retx_float: assert property (ce && pin.read_select_n && !pop && !rst_active |=> rptr == $past(rptr))
    else $error("read pointer moved with select high");
  a_cfg_latch: assert property (ce && master_active |=> cfg.sync_flags == $past(pin.flag_timing_sel)
                                && cfg.parallel_prog == $past(pin.offset_access_n))
    else $error("configuration not latched");
  a_serial_shift: assert property (ce && shift |=> empty_off[0] == $past(pin.fall_through_si))
    else $error("serial bit not shifted");
  a_async_ae: assert property (ce && !rst_active && !cfg.sync_flags && ae && !wr_evt |=> !almost_empty_n)
    else $error("almost empty not asserted");
  a_async_af: assert property (ce && !rst_active && !cfg.sync_flags && af && wr_evt |=> !almost_full_n)
    else $error("almost full not asserted");

endmodule : fifo_read_select

// *** testbench/fifo_ctrl_model.sv ***
`timescale 1ns/1ps

// Controller on the pin side; changes pins by NBA right after a rising edge
// The pin filter drops one-cycle pulses, so every strobe and data word stands two cycles
module fifo_ctrl_model
  import fifo_rsel_pkg::*;
(
  input  wire logic clk,  // Controller clock
  output pins_s     pins  // Device pins
);
  initial begin
    pins = PINS_RESET;
    pins.output_en_n = 1'b0;
  end

  task set_cfg(input logic [5:0] c);
    @(posedge clk);
    {pins.write_port_io_std_sel, pins.read_port_io_std_sel, pins.system_io_std_sel} <= c[5:3];
    pins.flag_timing_sel <= c[2];
    {pins.default_pick_1, pins.default_pick_0} <= c[1:0];
    pins.fall_through_si <= 1'b1;
    pins.offset_access_n <= 1'b1;
  endtask : set_cfg

  task release_master();
    @(posedge clk);
    pins.master_reset_n <= 1'b1;
  endtask : release_master

  // Stores the word twice: write enable is a level seen for two cycles
  task write_word(input logic [DATA_W-1:0] d);
    @(posedge clk);
    pins.offset_access_n <= 1'b1;
    pins.data_in         <= d;
    pins.write_en_n      <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    pins.write_en_n      <= 1'b1;
  endtask : write_word

  task read_word();
    @(posedge clk);
    pins.offset_access_n <= 1'b1;
    pins.read_en_n       <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    pins.read_en_n       <= 1'b1;
  endtask : read_word

  task set_select(input logic v);
    @(posedge clk);
    pins.read_select_n <= v;
    pins.read_en_n     <= 1'b1;
  endtask : set_select

  task set_load(input logic v);
    @(posedge clk);
    pins.offset_access_n <= v;
  endtask : set_load

  task pulse_retransmit();
    @(posedge clk);
    pins.retransmit_n <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    pins.retransmit_n <= 1'b1;
  endtask : pulse_retransmit
endmodule : fifo_ctrl_model

// *** testbench/fifo_read_select_and_config_test.sv ***
`timescale 1ns/1ps

module fifo_read_select_and_config_test
  import fifo_rsel_pkg::*;
;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic              ce = 1'b1;
  pins_s             pins;
  apb_req_s          apb_req = '0;
  apb_rsp_s          apb_rsp;
  logic [DATA_W-1:0] data_out_bus;
  logic              data_out_oe;
  logic              empty_flag_n;
  logic              almost_empty_n;
  logic              almost_full_n;
  logic              full_flag_n;
  cfg_s              cfg;
  int                errors = 0;
  int                samples_checked = 0;
  logic [32:0]       exp_q[$];
  logic [5:0]        c;
  logic [3:0]        dflt;
  logic [7:0]        offs;
  logic [DATA_W-1:0] w1;
  logic [DATA_W-1:0] w2;

  always #5 clk = ~clk;

  fifo_ctrl_model u_ctrl (.clk(clk), .pins(pins));

  fifo_read_select u_dut (
    .clk(clk), .rstn(rstn), .ce(ce), .pins(pins), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .data_out_bus(data_out_bus), .data_out_oe(data_out_oe), .empty_flag_n(empty_flag_n),
    .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n), .full_flag_n(full_flag_n), .cfg(cfg));

  task check(input logic [DATA_W-1:0] act, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (act !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask : check

  // APB master; the expected response is noted before the transfer
  task apb(input logic [11:0] a, input logic wr, input logic [31:0] wd, input logic [32:0] exp);
    int n;
    exp_q.push_back(exp);
    @(posedge clk);
    apb_req <= '{paddr: a, pwrite: wr, pwdata: wd, psel: 1'b1, penable: 1'b0};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (apb_rsp.pready !== 1'b1) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  // Response watcher takes the oldest note at each completed transfer
  always @(posedge clk) begin
    if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1) begin
      samples_checked++;
      if (exp_q.size() == 0) begin
        errors++;
        $display("CHECK FAILED t=%0t got=%h exp=none", $time, {apb_rsp.pslverr, apb_rsp.prdata});
      end else if ({apb_rsp.pslverr, apb_rsp.prdata} !== exp_q[0]) begin
        errors++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {apb_rsp.pslverr, apb_rsp.prdata}, exp_q[0]);
        void'(exp_q.pop_front());
      end else begin
        void'(exp_q.pop_front());
      end
    end
  end

  task finish_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h5b9a));
    c    = 6'($urandom());
    w1   = {4'h9, 32'($urandom())};
    w2   = {4'h6, 32'($urandom())};
    offs = 8'($urandom());
    u_ctrl.set_cfg(c);
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    check(36'(data_out_oe), 36'h1);
    u_ctrl.release_master();
    repeat (8) @(posedge clk);
    check(36'(cfg), 36'({c[5:3], 1'b1, 1'b1, c[2]}));
    check(36'(data_out_oe), 36'h0);
    dflt = DEFAULT_OFF[{1'b1, c[1:0]}];
    apb(ADDR_OFFSETS, 1'b0, 32'h0, {1'b0, 20'h0, dflt, 4'h0, dflt});
    check(36'(empty_flag_n), 36'h1);
    u_ctrl.write_word(w1);
    repeat (12) @(posedge clk);
    check(36'(empty_flag_n), 36'h0);
    check(data_out_bus, w1);
    check(36'(data_out_oe), 36'h0);
    u_ctrl.set_select(1'b0);
    repeat (6) @(posedge clk);
    check(36'(data_out_oe), 36'h1);
    check(data_out_bus, w1);
    u_ctrl.write_word(w2);
    repeat (10) @(posedge clk);
    check(data_out_bus, w1);
    u_ctrl.read_word();
    repeat (6) @(posedge clk);
    check(data_out_bus, w2);
    u_ctrl.set_select(1'b1);
    repeat (6) @(posedge clk);
    check(36'(data_out_oe), 36'h0);
    u_ctrl.pulse_retransmit();
    repeat (8) @(posedge clk);
    check(36'(empty_flag_n), 36'h0);
    check(data_out_bus, w2);
    apb(ADDR_OFFSETS, 1'b1, {20'h0, offs[7:4], 4'h0, offs[3:0]}, 33'h100000000);
    apb(ADDR_STATUS, 1'b1, 32'h0, 33'h100000000);
    apb(12'h0ff, 1'b0, 32'h0, 33'h100000000);
    apb(ADDR_OFFSETS, 1'b0, 32'h0, {1'b0, 20'h0, dflt, 4'h0, dflt});
    u_ctrl.set_load(1'b0);
    repeat (6) @(posedge clk);
    apb(ADDR_OFFSETS, 1'b1, {20'h0, offs[7:4], 4'h0, offs[3:0]}, 33'h0);
    apb(ADDR_OFFSETS, 1'b0, 32'h0, {1'b0, 20'h0, offs[7:4], 4'h0, offs[3:0]});
    u_ctrl.set_load(1'b1);
    repeat (4) @(posedge clk);
    check(36'(exp_q.size()), 36'h0);
    finish_test();
  end
endmodule : fifo_read_select_and_config_test
